// file: pkg/ccg_defs.svh
`ifndef CCG_DEFS_SVH
`define CCG_DEFS_SVH

// System clock rate in kHz (200 MHz)
`define CCG_ACLK_KHZ        32'h00030d40

// Processor/memory frequency per select code, kHz
`define CCG_KHZ_50_0        32'h0000c350
`define CCG_KHZ_75_0        32'h000124f8
`define CCG_KHZ_83_3        32'h00014564
`define CCG_KHZ_68_5        32'h00010b94
`define CCG_KHZ_60_0        32'h0000ea60
`define CCG_KHZ_66_8        32'h000104f0
// Bus exceptions
`define CCG_KHZ_32_0        32'h00007d00
`define CCG_KHZ_33_3        32'h00008214
// Fixed clocks
`define CCG_KHZ_REF         32'h000037ee
`define CCG_KHZ_24          32'h00005dc0
`define CCG_KHZ_48          32'h0000bb80

// Spread: total span 3.0 % (two times 1.5 %) in per mille
`define CCG_SPREAD_SPAN_PM  32'h0000001e
`define CCG_PERMILLE        32'h000003e8
`define CCG_TRI_MAX         8'hff

// Final SETTLE count; straps are latched on the 5th cycle after reset release
`define CCG_SETTLE_CYC      3'h3

// Strap pin index
`define CCG_STRAP_VOLT      0
`define CCG_STRAP_FS1       1
`define CCG_STRAP_FS2       2
`define CCG_STRAP_MODE      3
`define CCG_STRAP_FS0       4
// Shared mode pin index
`define CCG_SHR_PSTOP       0
`define CCG_SHR_BSTOP       1

// Register map
`define CCG_ADDR_W          12
`define CCG_REG_STATUS      12'h000
`define CCG_REG_CTRL        12'h004
`define CCG_REG_FREQ        12'h008
`define CCG_CTRL_RST        16'h0100
`define CCG_RESP_OKAY       2'h0
`define CCG_RESP_SLVERR     2'h2

`endif

// file: pkg/ccg_pkg.sv
package ccg_pkg;
  typedef enum logic [2:0] {
    CCG_ST_RESET  = 3'b001,
    CCG_ST_SETTLE = 3'b010,
    CCG_ST_RUN    = 3'b100
  } ccg_strap_st_t;
  typedef logic [2:0] ccg_fsel_t;
endpackage

// file: hdl/ccg_nco.sv
`timescale 1ns/1ps
`include "ccg_defs.svh"

// Phase accumulator; square wave from the top bit
module ccg_nco (
  input  wire logic        aclk,    // system clock
  input  wire logic        aresetn, // sync reset, low active
  input  wire logic [31:0] inc,     // phase step per cycle
  output logic             clk_q    // synthesized clock
);
  logic [31:0] phase_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_q <= 32'h00000000;
    end else begin
      phase_q <= phase_q + inc;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_q <= 1'b0;
    end else begin
      clk_q <= phase_q[31];
    end
  end
endmodule

// file: hdl/ccg_top.sv
`timescale 1ns/1ps
`include "ccg_defs.svh"

module ccg_top (
  input  wire logic        aclk,            // system clock, 200 MHz
  input  wire logic        aresetn,         // sync reset, low active
  // AXI4-Lite slave
  input  wire logic [11:0] s_axi_awaddr,    // write address
  input  wire logic        s_axi_awvalid,   // write address valid
  output logic             s_axi_awready,   // write address ready
  input  wire logic [31:0] s_axi_wdata,     // write data
  input  wire logic [3:0]  s_axi_wstrb,     // write strobes
  input  wire logic        s_axi_wvalid,    // write data valid
  output logic             s_axi_wready,    // write data ready
  output logic [1:0]       s_axi_bresp,     // write response
  output logic             s_axi_bvalid,    // write response valid
  input  wire logic        s_axi_bready,    // write response ready
  input  wire logic [11:0] s_axi_araddr,    // read address
  input  wire logic        s_axi_arvalid,   // read address valid
  output logic             s_axi_arready,   // read address ready
  output logic [31:0]      s_axi_rdata,     // read data
  output logic [1:0]       s_axi_rresp,     // read response
  output logic             s_axi_rvalid,    // read data valid
  input  wire logic        s_axi_rready,    // read data ready
  // Dual-function strap pins
  input  wire logic [4:0]  strap_pin_i,     // pin level
  output logic [4:0]       strap_pin_o,     // clock driven out
  output logic [4:0]       strap_pin_oe_n,  // low while driving
  // Mode-shared pins: stop inputs or clock outputs
  input  wire logic [1:0]  shared_pin_i,    // pin level
  output logic [1:0]       shared_pin_o,    // clock driven out
  output logic [1:0]       shared_pin_oe_n, // low while driving
  // Spread controls
  input  wire logic        ss_en_n,         // spread enable, low active
  input  wire logic        ss_type,         // 1 down, 0 center
  // Clock outputs
  output logic [3:0]       proc_clk_out,    // processor clocks
  output logic [11:0]      mem_clk_out,     // memory clocks
  output logic [3:0]       gated_bus_clk_out, // gated bus clocks 1..4
  output logic             intr_ctrl_clk_out, // interrupt-controller clock
  output logic             proc_buf_2v5     // 1 selects 2.5 V drivers
);
  import ccg_pkg::*;

  function automatic logic [31:0] proc_khz(input ccg_fsel_t sel);
    case (sel)
      3'h0:    proc_khz = `CCG_KHZ_50_0;
      3'h1:    proc_khz = `CCG_KHZ_75_0;
      3'h2:    proc_khz = `CCG_KHZ_83_3;
      3'h3:    proc_khz = `CCG_KHZ_68_5;
      3'h4:    proc_khz = `CCG_KHZ_83_3;
      3'h5:    proc_khz = `CCG_KHZ_75_0;
      3'h6:    proc_khz = `CCG_KHZ_60_0;
      default: proc_khz = `CCG_KHZ_66_8;
    endcase
  endfunction

  function automatic logic [31:0] bus_khz(input ccg_fsel_t sel);
    case (sel)
      3'h1:    bus_khz = `CCG_KHZ_32_0;
      3'h4:    bus_khz = `CCG_KHZ_33_3;
      default: bus_khz = proc_khz(sel) >> 1;
    endcase
  endfunction

  function automatic logic [31:0] nco_inc(input logic [31:0] khz);
    logic [63:0] t;
    t = {khz, 32'h00000000} / {32'h00000000, `CCG_ACLK_KHZ};
    nco_inc = t[31:0];
  endfunction

  // Spread applied to a nominal step; tri is triangle position
  function automatic logic [31:0] spread_inc(input logic [31:0] inc, input logic [7:0] tri_pos,
                                             input logic on, input logic down);
    logic [63:0] span;
    logic [63:0] frac;
    span = ({32'h00000000, inc} * {32'h00000000, `CCG_SPREAD_SPAN_PM}) / {32'h00000000, `CCG_PERMILLE};
    frac = (span * {56'h00000000000000, tri_pos}) / {56'h00000000000000, `CCG_TRI_MAX};
    if (!on) begin
      spread_inc = inc;
    end else if (down) begin
      spread_inc = inc - frac[31:0];
    end else begin
      spread_inc = inc - span[32:1] + frac[31:0];
    end
  endfunction

  // Strap capture sequencer
  ccg_strap_st_t st_q;
  logic [2:0]    settle_q;
  logic [4:0]    strap_s1_q;
  logic [4:0]    strap_s2_q;
  logic [3:0]    strap_latch_q;
  logic          mode_q;
  logic          run;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_s1_q <= 5'h00;
      strap_s2_q <= 5'h00;
    end else begin
      strap_s1_q <= strap_pin_i;
      strap_s2_q <= strap_s1_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q     <= CCG_ST_RESET;
      settle_q <= 3'h0;
    end else begin
      case (st_q)
        CCG_ST_RESET: begin
          st_q <= CCG_ST_SETTLE;
        end
        CCG_ST_SETTLE: begin
          settle_q <= settle_q + 3'h1;
          if (settle_q == `CCG_SETTLE_CYC) begin
            st_q <= CCG_ST_RUN;
          end
        end
        CCG_ST_RUN: begin
          st_q <= CCG_ST_RUN;
        end
        default: begin
          st_q <= CCG_ST_RESET;
        end
      endcase
    end
  end

  assign run = (st_q == CCG_ST_RUN);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_latch_q <= 4'h0;
      mode_q        <= 1'b0;
    end else if (st_q == CCG_ST_SETTLE && settle_q == `CCG_SETTLE_CYC) begin
      strap_latch_q <= {strap_s2_q[`CCG_STRAP_VOLT], strap_s2_q[`CCG_STRAP_FS2],
                        strap_s2_q[`CCG_STRAP_FS1], strap_s2_q[`CCG_STRAP_FS0]};
      mode_q        <= strap_s2_q[`CCG_STRAP_MODE];
    end
  end

  ccg_fsel_t fsel;
  assign fsel = strap_latch_q[2:0];
  assign proc_buf_2v5 = strap_latch_q[3];

  // Spread inputs and stop requests from pins
  logic [3:0] in_s1_q;
  logic [3:0] in_s2_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_s1_q <= 4'hf;
      in_s2_q <= 4'hf;
    end else begin
      in_s1_q <= {ss_type, ss_en_n, shared_pin_i};
      in_s2_q <= in_s1_q;
    end
  end

  logic pstop_run;
  logic bstop_run;
  assign pstop_run = mode_q | in_s2_q[`CCG_SHR_PSTOP];
  assign bstop_run = mode_q | in_s2_q[`CCG_SHR_BSTOP];

  // spread on when enable low; type picks shape
  logic spread_on;
  logic spread_down;
  assign spread_on   = ~in_s2_q[2];
  assign spread_down = in_s2_q[3];

  // Triangle sweep for modulation
  logic [15:0] sweep_div_q;
  logic [15:0] sweep_cnt_q;
  logic [7:0]  tri_q;
  logic        tri_up_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sweep_cnt_q <= 16'h0000;
      tri_q       <= 8'h00;
      tri_up_q    <= 1'b1;
    end else if (sweep_cnt_q >= sweep_div_q) begin
      sweep_cnt_q <= 16'h0000;
      if (tri_up_q) begin
        tri_q    <= tri_q + 8'h01;
        tri_up_q <= (tri_q + 8'h01) != `CCG_TRI_MAX;
      end else begin
        tri_q    <= tri_q - 8'h01;
        tri_up_q <= (tri_q - 8'h01) == 8'h00;
      end
    end else begin
      sweep_cnt_q <= sweep_cnt_q + 16'h0001;
    end
  end

  logic [31:0] proc_inc;
  logic [31:0] bus_inc;
  assign proc_inc = spread_inc(nco_inc(proc_khz(fsel)), tri_q, spread_on, spread_down);
  assign bus_inc  = spread_inc(nco_inc(bus_khz(fsel)), tri_q, spread_on, spread_down);

  logic proc_clk;
  logic bus_clk;
  logic ref_clk;
  logic clk24;
  logic clk48;

  ccg_nco u_proc_nco (.aclk(aclk), .aresetn(aresetn), .inc(proc_inc), .clk_q(proc_clk));
  ccg_nco u_bus_nco  (.aclk(aclk), .aresetn(aresetn), .inc(bus_inc),  .clk_q(bus_clk));
  ccg_nco u_ref_nco  (.aclk(aclk), .aresetn(aresetn), .inc(nco_inc(`CCG_KHZ_REF)), .clk_q(ref_clk));
  ccg_nco u_24_nco   (.aclk(aclk), .aresetn(aresetn), .inc(nco_inc(`CCG_KHZ_24)),  .clk_q(clk24));
  ccg_nco u_48_nco   (.aclk(aclk), .aresetn(aresetn), .inc(nco_inc(`CCG_KHZ_48)),  .clk_q(clk48));

  // Gate enables change only while the source clock is low
  logic proc_en_q;
  logic bus_en_q;
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      proc_en_q <= 1'b0;
    end else if (!proc_clk) begin
      proc_en_q <= pstop_run;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      bus_en_q <= 1'b0;
    end else if (!bus_clk) begin
      bus_en_q <= bstop_run;
    end
  end

  // Output stage, all clocks aligned by one register
  logic proc_g_q;
  logic bus_g_q;
  logic bus_f_q;
  logic mem_q;
  logic ref_q;
  logic c24_q;
  logic c48_q;

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      proc_g_q <= 1'b0;
      bus_g_q  <= 1'b0;
      bus_f_q  <= 1'b0;
      mem_q    <= 1'b0;
      ref_q    <= 1'b0;
      c24_q    <= 1'b0;
      c48_q    <= 1'b0;
    end else begin
      proc_g_q <= proc_clk & proc_en_q;
      bus_g_q  <= bus_clk & bus_en_q;
      bus_f_q  <= bus_clk;
      mem_q    <= proc_clk;
      ref_q    <= ref_clk;
      c24_q    <= clk24;
      c48_q    <= clk48;
    end
  end

  assign proc_clk_out      = {4{proc_g_q}};
  assign mem_clk_out       = {12{mem_q}};
  assign gated_bus_clk_out = {4{bus_g_q}};
  assign intr_ctrl_clk_out = ref_q;

  // strap pins drive clocks only after capture
  always_comb begin
    strap_pin_o                  = 5'h00;
    strap_pin_o[`CCG_STRAP_VOLT] = ref_q;
    strap_pin_o[`CCG_STRAP_FS1]  = bus_f_q;
    strap_pin_o[`CCG_STRAP_FS2]  = bus_g_q;
    strap_pin_o[`CCG_STRAP_MODE] = c24_q;
    strap_pin_o[`CCG_STRAP_FS0]  = c48_q;
    strap_pin_oe_n               = run ? 5'h00 : 5'h1f;
  end

  // shared pins: inputs in mobile, outputs in desktop
  always_comb begin
    shared_pin_o                 = 2'h0;
    shared_pin_o[`CCG_SHR_PSTOP] = ref_q;
    shared_pin_o[`CCG_SHR_BSTOP] = bus_g_q;
    shared_pin_oe_n              = (run && mode_q) ? 2'h0 : 2'h3;
  end

  // AXI4-Lite register slave
  logic        aw_have_q;
  logic        w_have_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready  = !w_have_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      awaddr_q  <= 12'h000;
    end else if (s_axi_awvalid && !aw_have_q) begin
      aw_have_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end else if (aw_have_q && w_have_q && !bvalid_q) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      wdata_q  <= 32'h00000000;
      wstrb_q  <= 4'h0;
    end else if (s_axi_wvalid && !w_have_q) begin
      w_have_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (aw_have_q && w_have_q && !bvalid_q) begin
      w_have_q <= 1'b0;
    end
  end

  logic wr_go;
  assign wr_go = aw_have_q && w_have_q && !bvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sweep_div_q <= `CCG_CTRL_RST;
    end else if (wr_go && {awaddr_q[11:2], 2'b00} == `CCG_REG_CTRL) begin
      if (wstrb_q[0]) begin
        sweep_div_q[7:0] <= wdata_q[7:0];
      end
      if (wstrb_q[1]) begin
        sweep_div_q[15:8] <= wdata_q[15:8];
      end
    end
  end

  function automatic logic known_addr(input logic [11:0] a);
    known_addr = ({a[11:2], 2'b00} == `CCG_REG_STATUS) || ({a[11:2], 2'b00} == `CCG_REG_CTRL)
              || ({a[11:2], 2'b00} == `CCG_REG_FREQ);
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `CCG_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= known_addr(awaddr_q) ? `CCG_RESP_OKAY : `CCG_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Status word: straps, spread state, gate state, sequencer
  logic [31:0] status;
  assign status = {21'h000000, ~spread_on & spread_down, run, bus_en_q, proc_en_q,
                   spread_down, spread_on, mode_q, strap_latch_q};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= `CCG_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rresp_q  <= known_addr(s_axi_araddr) ? `CCG_RESP_OKAY : `CCG_RESP_SLVERR;
      case ({s_axi_araddr[11:2], 2'b00})
        `CCG_REG_STATUS: rdata_q <= status;
        `CCG_REG_CTRL:   rdata_q <= {16'h0000, sweep_div_q};
        `CCG_REG_FREQ:   rdata_q <= proc_khz(fsel);
        default:              rdata_q <= 32'h00000000;
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
endmodule

// file: bench/ccg_pm_model.sv
`timescale 1ns/1ps

module ccg_pm_model (
  input  wire logic       aclk,      // system clock
  input  wire logic       aresetn,   // sync reset
  input  wire logic       proc_clk,  // processor clock seen
  input  wire logic       bus_clk,   // gated bus clock seen
  input  wire logic [1:0] want_stop, // 0 proc, 1 bus
  output logic      [1:0] stop_n     // stop requests, low stops
);
  logic [1:0] seen;
  logic [1:0] edge_q;
  logic [7:0] cnt_q [2];

  assign seen = {bus_clk, proc_clk};

  always @(posedge aclk) begin
    edge_q <= seen;
    for (int i = 0; i < 2; i++) begin
      if (!aresetn || (!want_stop[i] && !stop_n[i])) begin
        stop_n[i] <= 1'b1;
        cnt_q[i]  <= 8'h00;
      end else if (stop_n[i]) begin
        if (seen[i] && !edge_q[i] && cnt_q[i] != 8'hff) cnt_q[i] <= cnt_q[i] + 8'h01;
        if (want_stop[i] && cnt_q[i] >= (i ? 8'h0a : 8'h64)) stop_n[i] <= 1'b0;
      end
    end
  end
endmodule

// file: bench/ccg_top_assertions.sv
`timescale 1ns/1ps

module ccg_top_assertions (
  input wire logic        aclk,              // clock
  input wire logic        aresetn,           // reset
  input wire logic [1:0]  shared_pin_i,      // stop pins
  input wire logic [1:0]  shared_pin_oe_n,   // shared oe
  input wire logic [4:0]  strap_pin_o,       // strap clocks
  input wire logic [4:0]  strap_pin_oe_n,    // strap oe
  input wire logic [3:0]  proc_clk_out,      // proc clocks
  input wire logic [11:0] mem_clk_out,       // mem clocks
  input wire logic [3:0]  gated_bus_clk_out, // bus clocks
  input wire logic        intr_ctrl_clk_out, // intr clock
  input wire logic        proc_buf_2v5       // volt select
);
  logic [4:0] plow_q;
  logic [4:0] blow_q;

  // Cycles a stop request has been held low
  always_ff @(posedge aclk) begin
    if (!aresetn || shared_pin_i[0] || !shared_pin_oe_n[0]) plow_q <= 5'h00;
    else if (plow_q != 5'h1f) plow_q <= plow_q + 5'h01;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || shared_pin_i[1] || !shared_pin_oe_n[1]) blow_q <= 5'h00;
    else if (blow_q != 5'h1f) blow_q <= blow_q + 5'h01;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_brel;
    $rose(shared_pin_i[1]) && shared_pin_oe_n[1];
  endsequence
  sequence s_bstart;
    ##[1:16] $rose(gated_bus_clk_out[0]);
  endsequence

  property p_proc_held; plow_q >= 5'h0c |-> proc_clk_out == 4'h0; endproperty
  a_proc_held: assert property (p_proc_held) else $error("proc clock not held low");
  property p_proc_start; $rose(shared_pin_i[0]) && shared_pin_oe_n[0] |-> ##[1:16] $rose(proc_clk_out[0]);
  endproperty
  a_proc_start: assert property (p_proc_start) else $error("proc clock late to start");
  property p_desk; $fell(shared_pin_i[0]) && !shared_pin_oe_n[0] |-> ##[1:8] $rose(proc_clk_out[0]); endproperty
  a_desk: assert property (p_desk) else $error("proc clock gated in desktop mode");
  property p_bus_held; blow_q >= 5'h0c |-> gated_bus_clk_out == 4'h0 && !strap_pin_o[2]; endproperty
  a_bus_held: assert property (p_bus_held) else $error("bus clock not held low");
  property p_bus_start; s_brel |-> s_bstart; endproperty
  a_bus_start: assert property (p_bus_start) else $error("bus clock late to start");
  property p_bus_pulse; $rose(gated_bus_clk_out[0]) |-> gated_bus_clk_out[0] [*2]; endproperty
  a_bus_pulse: assert property (p_bus_pulse) else $error("bus clock runt pulse");
  property p_free_runs; blow_q == 5'h0c |-> ##[1:6] $changed(strap_pin_o[1]); endproperty
  a_free_runs: assert property (p_free_runs) else $error("free bus clock stopped");
  property p_mem_runs; plow_q == 5'h0c |-> ##[1:4] $changed(mem_clk_out[0]); endproperty
  a_mem_runs: assert property (p_mem_runs) else $error("memory clock stopped");
  property p_intr; $rose(intr_ctrl_clk_out) |-> ##[5:8] $fell(intr_ctrl_clk_out); endproperty
  a_intr: assert property (p_intr) else $error("intr clock off rate");
  property p_volt; !strap_pin_oe_n[0] |=> $stable(proc_buf_2v5); endproperty
  a_volt: assert property (p_volt) else $error("voltage strap changed");
  property p_oe; (strap_pin_oe_n == 5'h00 || strap_pin_oe_n == 5'h1f)
    && (shared_pin_oe_n == 2'h3 || (shared_pin_oe_n == 2'h0 && strap_pin_oe_n == 5'h00)); endproperty
  a_oe: assert property (p_oe) else $error("pin direction mixed");
endmodule

bind ccg_top ccg_top_assertions u_chk (
  .aclk(aclk), .aresetn(aresetn), .shared_pin_i(shared_pin_i), .shared_pin_oe_n(shared_pin_oe_n),
  .strap_pin_o(strap_pin_o), .strap_pin_oe_n(strap_pin_oe_n), .proc_clk_out(proc_clk_out),
  .mem_clk_out(mem_clk_out), .gated_bus_clk_out(gated_bus_clk_out),
  .intr_ctrl_clk_out(intr_ctrl_clk_out), .proc_buf_2v5(proc_buf_2v5));

// file: bench/ccg_top_tb_top.sv
`timescale 1ns/1ps
`include "ccg_defs.svh"

module ccg_top_tb_top;
  import ccg_pkg::*;
  logic        aclk, aresetn, ss_en_n, ss_type, intr_clk, buf_2v5;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr, mem_clk;
  logic [31:0] wdata, rdata, d, np, nb, eb, n24, n48, n6;
  logic [31:0] khz [8];
  logic [3:0]  wstrb, proc_clk, gbus_clk;
  logic [4:0]  strap_drv, strap_i, strap_o, strap_oe_n;
  logic [1:0]  bresp, rresp, r, want_stop, stop_n, sh_i, sh_o, sh_oe_n;
  int          n_fail, checks;

  assign strap_i = (strap_oe_n & strap_drv) | (~strap_oe_n & strap_o);
  assign sh_i    = (sh_oe_n & stop_n) | (~sh_oe_n & sh_o);

  ccg_top dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .strap_pin_i(strap_i),
    .strap_pin_o(strap_o), .strap_pin_oe_n(strap_oe_n), .shared_pin_i(sh_i), .shared_pin_o(sh_o),
    .shared_pin_oe_n(sh_oe_n), .ss_en_n(ss_en_n), .ss_type(ss_type), .proc_clk_out(proc_clk),
    .mem_clk_out(mem_clk), .gated_bus_clk_out(gbus_clk), .intr_ctrl_clk_out(intr_clk),
    .proc_buf_2v5(buf_2v5));

  ccg_pm_model u_pm (
    .aclk(aclk), .aresetn(aresetn), .proc_clk(proc_clk[0]), .bus_clk(gbus_clk[0]),
    .want_stop(want_stop), .stop_n(stop_n));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task print_verdict;
    if (n_fail == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task near(input logic [31:0] n, input logic [31:0] e);
    check({31'h0, n + 2 >= e && n <= e + 2}, 32'h1);
  endtask

  task axi_wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task axi_rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task do_reset(input logic [4:0] s);
    @(posedge aclk);
    aresetn <= 1'b0;
    strap_drv <= s;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (int t = 0; t < 40 && strap_oe_n !== 5'h00; t++) @(posedge aclk);
    check(strap_oe_n, 5'h00);
  endtask

  // Rising edges of the clock outputs over 1000 cycles
  task count_edges;
    logic [4:0] pv;
    logic [4:0] cv;
    {np, nb, n24, n48, n6} = '0;
    pv = {sh_o[1], strap_o[4:3], gbus_clk[0], proc_clk[0]};
    repeat (1000) begin
      @(posedge aclk);
      cv = {sh_o[1], strap_o[4:3], gbus_clk[0], proc_clk[0]};
      np += {31'h0, cv[0] & ~pv[0]};
      nb += {31'h0, cv[1] & ~pv[1]};
      n24 += {31'h0, cv[2] & ~pv[2]};
      n48 += {31'h0, cv[3] & ~pv[3]};
      n6 += {31'h0, cv[4] & ~pv[4]};
      pv = cv;
    end
  endtask

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  initial begin
    repeat (30000) @(posedge aclk);
    n_fail++;
    print_verdict;
  end

  initial begin
    n_fail = 0;
    checks = 0;
    {awvalid, wvalid, bready, arvalid, rready, aresetn, ss_type, want_stop} = '0;
    {awaddr, araddr, wdata, strap_drv} = '0;
    wstrb = 4'hf;
    ss_en_n = 1'b1;
    khz = '{`CCG_KHZ_50_0, `CCG_KHZ_75_0, `CCG_KHZ_83_3, `CCG_KHZ_68_5,
            `CCG_KHZ_83_3, `CCG_KHZ_75_0, `CCG_KHZ_60_0, `CCG_KHZ_66_8};
    // Desktop mode through every select code
    for (int c = 0; c < 8; c++) begin
      do_reset({c[0], 1'b1, c[2], c[1], c[0]});
      count_edges;
      eb = (c == 1) ? `CCG_KHZ_32_0 : (c == 4) ? `CCG_KHZ_33_3 : khz[c] / 2;
      near(np, khz[c] * 1000 / `CCG_ACLK_KHZ);
      near(nb, eb * 1000 / `CCG_ACLK_KHZ);
      near(n6, eb * 1000 / `CCG_ACLK_KHZ);
      near(n24, `CCG_KHZ_24 * 1000 / `CCG_ACLK_KHZ);
      near(n48, `CCG_KHZ_48 * 1000 / `CCG_ACLK_KHZ);
      axi_rd(`CCG_REG_FREQ, d, r);
      check(d, khz[c]);
      axi_rd(`CCG_REG_STATUS, d, r);
      check(d & 32'h3ff, {22'h0, 3'h7, 2'h0, 1'b1, c[0], c[2:0]});
      check(buf_2v5, c[0]);
    end
    // Mobile mode, slowest code
    do_reset(5'h00);
    axi_rd(`CCG_REG_CTRL, d, r);
    check(d, {16'h0, `CCG_CTRL_RST});
    axi_wr(`CCG_REG_CTRL, 32'h1, r);
    check(r, `CCG_RESP_OKAY);
    axi_rd(`CCG_REG_CTRL, d, r);
    check(d, 32'h1);
    axi_wr(12'h00c, 32'h5, r);
    check(r, `CCG_RESP_SLVERR);
    axi_rd(12'h00c, d, r);
    check({d[29:0], r}, `CCG_RESP_SLVERR);
    for (int k = 0; k < 3; k++) begin
      @(posedge aclk);
      {ss_en_n, ss_type} <= k[1:0];
      repeat (8) @(posedge aclk);
      axi_rd(`CCG_REG_STATUS, d, r);
      check(d[6:5], {k[0], ~k[1]});
    end
    @(posedge aclk);
    {ss_en_n, ss_type} <= 2'b01;
    repeat (20) @(posedge aclk);
    count_edges;
    near(np, `CCG_KHZ_50_0 * (`CCG_PERMILLE - `CCG_SPREAD_SPAN_PM / 2) / `CCG_PERMILLE
         * 1000 / `CCG_ACLK_KHZ);
    near(n48, `CCG_KHZ_48 * 1000 / `CCG_ACLK_KHZ);
    // spread off, never with type high
    {ss_en_n, ss_type} <= 2'b10;
    for (int g = 0; g < 2; g++) begin
      @(posedge aclk);
      want_stop[g] <= 1'b1;
      repeat (40) @(posedge aclk);
      check(stop_n[g], 1'b0);
      check(g ? {gbus_clk, strap_o[2]} : {1'b0, proc_clk}, 5'h00);
      axi_rd(`CCG_REG_STATUS, d, r);
      check(d[8:7], g ? 2'b01 : 2'b10);
      want_stop[g] <= 1'b0;
      repeat (40) @(posedge aclk);
      axi_rd(`CCG_REG_STATUS, d, r);
      check(d[8:7], 2'b11);
    end
    print_verdict;
  end
endmodule
